/* File: core/interval_timebase_timer.sv */
`timescale 1ns/10ps
`include "interval_timebase_timer_consts.svh"
// Function
// - mode bit 0: count system prescaler taps /8192,/4096,/2048,/512,/256,/128,/32,/8
// - mode bit 1, select bit2 0: code 000 counts watch prescaler at 1 s
// - time-base codes 001, 010, 011 give 0.5 s, 0.25 s, 0.03125 s
// - mode bit and select bit2 both 1: watch prescaler and counter held reset
module interval_timebase_timer
	import interval_timebase_timer_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic watch_clk, // watch subclock pin
	output logic irq // level interrupt
);

	// ----------------------------------------
	// derived tap masks
	// ----------------------------------------
	localparam logic [12:0] SYS_M0 = 13'(`SYS_DIV0 - 1);
	localparam logic [12:0] SYS_M1 = 13'(`SYS_DIV1 - 1);
	localparam logic [12:0] SYS_M2 = 13'(`SYS_DIV2 - 1);
	localparam logic [12:0] SYS_M3 = 13'(`SYS_DIV3 - 1);
	localparam logic [12:0] SYS_M4 = 13'(`SYS_DIV4 - 1);
	localparam logic [12:0] SYS_M5 = 13'(`SYS_DIV5 - 1);
	localparam logic [12:0] SYS_M6 = 13'(`SYS_DIV6 - 1);
	localparam logic [12:0] SYS_M7 = 13'(`SYS_DIV7 - 1);
	localparam logic [14:0] TB_M0 =
		15'((64'(`TB_PERIOD0_US) * 64'(`WATCH_HZ)) / 64'd1000000 - 64'd1);
	localparam logic [14:0] TB_M1 =
		15'((64'(`TB_PERIOD1_US) * 64'(`WATCH_HZ)) / 64'd1000000 - 64'd1);
	localparam logic [14:0] TB_M2 =
		15'((64'(`TB_PERIOD2_US) * 64'(`WATCH_HZ)) / 64'd1000000 - 64'd1);
	localparam logic [14:0] TB_M3 =
		15'((64'(`TB_PERIOD3_US) * 64'(`WATCH_HZ)) / 64'd1000000 - 64'd1);
	localparam logic [7:0] MODE_RST = `MODE_RESET;

	// ----------------------------------------
	// state
	// ----------------------------------------
	mode_s mode_q;
	count_t count_q;
	count_t count_d;
	logic status_q;
	logic mask_q;
	logic irq_q;
	logic [`SYS_PS_W-1:0] sys_ps_q;
	logic [`WATCH_PS_W-1:0] watch_ps_q;
	logic ws1_q;
	logic ws2_q;
	logic ws3_q;
	logic watch_rise;
	logic hold_w;
	logic tick_w;
	logic ovf_w;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic setup_w;
	logic wr_w;
	logic [31:0] rd_w;
	logic hit_w;

	assign setup_w = psel & ~penable;
	assign wr_w = psel & penable & pready_q & pwrite;

	// ----------------------------------------
	// apb slave: one wait-free access phase
	// ----------------------------------------
	always_comb begin
		rd_w = 32'h0000_0000;
		hit_w = 1'b1;
		unique case (paddr)
			`MODE_ADDR: rd_w = {24'h00_0000, mode_q[6:4], 1'b1, mode_q[3:0]};
			`COUNT_ADDR: rd_w = {24'h00_0000, count_q};
			`STATUS_ADDR: rd_w = {31'h0000_0000, status_q};
			`MASK_ADDR: rd_w = {31'h0000_0000, mask_q};
			default: hit_w = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup_w;
			if (setup_w) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_w;
				pslverr_q <= ~hit_w;
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// mode and mask registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= mode_s'({MODE_RST[7:5], MODE_RST[3:0]});
			mask_q <= 1'b0;
		end else if (wr_w) begin
			if (paddr == `MODE_ADDR) begin
				mode_q <= mode_s'({pwdata[7:5], pwdata[3:0]});
			end
			if (paddr == `MASK_ADDR) begin
				mask_q <= pwdata[`OVF_BIT];
			end
		end
	end

	// ----------------------------------------
	// watch pin synchroniser and edge
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ws1_q <= 1'b0;
			ws2_q <= 1'b0;
			ws3_q <= 1'b0;
		end else begin
			ws1_q <= watch_clk;
			ws2_q <= ws1_q;
			ws3_q <= ws2_q;
		end
	end

	assign watch_rise = ws2_q & ~ws3_q;
	assign hold_w = mode_q.timebase_mode_bit & mode_q.source_select_bit2;

	// ----------------------------------------
	// prescalers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_ps_q <= '0;
		end else begin
			sys_ps_q <= sys_ps_q + 13'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watch_ps_q <= '0;
		end else if (hold_w) begin
			watch_ps_q <= '0;
		end else if (watch_rise) begin
			watch_ps_q <= watch_ps_q + 15'h0001;
		end
	end

	// ----------------------------------------
	// source tick select
	// ----------------------------------------
	always_comb begin
		tick_w = 1'b0;
		if (!mode_q.timebase_mode_bit) begin
			unique case ({mode_q.source_select_bit2, mode_q.source_select_bit1,
				mode_q.source_select_bit0})
				3'h0: tick_w = (sys_ps_q & SYS_M0) == SYS_M0;
				3'h1: tick_w = (sys_ps_q & SYS_M1) == SYS_M1;
				3'h2: tick_w = (sys_ps_q & SYS_M2) == SYS_M2;
				3'h3: tick_w = (sys_ps_q & SYS_M3) == SYS_M3;
				3'h4: tick_w = (sys_ps_q & SYS_M4) == SYS_M4;
				3'h5: tick_w = (sys_ps_q & SYS_M5) == SYS_M5;
				3'h6: tick_w = (sys_ps_q & SYS_M6) == SYS_M6;
				3'h7: tick_w = (sys_ps_q & SYS_M7) == SYS_M7;
			endcase
		end else if (!mode_q.source_select_bit2) begin
			unique case ({mode_q.source_select_bit1, mode_q.source_select_bit0})
				2'h0: tick_w = watch_rise && (watch_ps_q & TB_M0) == TB_M0;
				2'h1: tick_w = watch_rise && (watch_ps_q & TB_M1) == TB_M1;
				2'h2: tick_w = watch_rise && (watch_ps_q & TB_M2) == TB_M2;
				2'h3: tick_w = watch_rise && (watch_ps_q & TB_M3) == TB_M3;
			endcase
		end
	end

	// ----------------------------------------
	// counter and overflow
	// ----------------------------------------
	assign ovf_w = ~hold_w & tick_w & (count_q == 8'hff);

	always_comb begin
		count_d = count_q;
		if (hold_w) begin
			count_d = 8'h00;
		end else if (tick_w) begin
			count_d = count_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 8'h00;
		end else begin
			count_q <= count_d;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= 1'b0;
		end else if (ovf_w) begin
			status_q <= 1'b1;
		end else if (wr_w && paddr == `STATUS_ADDR && pwdata[`OVF_BIT]) begin
			status_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= status_q & mask_q;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fast_tap_a: assert property (
		(!mode_q.timebase_mode_bit && {mode_q.source_select_bit2,
		mode_q.source_select_bit1, mode_q.source_select_bit0} == 3'h7)
		|-> (tick_w == (sys_ps_q[2:0] == 3'h7)))
		else $error("interval /8 tap wrong");

	slow_tap_a: assert property (
		(!mode_q.timebase_mode_bit && tick_w && {mode_q.source_select_bit2,
		mode_q.source_select_bit1, mode_q.source_select_bit0} == 3'h0)
		|-> (sys_ps_q == 13'h1fff))
		else $error("interval /8192 tap wrong");

	second_tap_a: assert property (
		(mode_q.timebase_mode_bit && tick_w && {mode_q.source_select_bit2,
		mode_q.source_select_bit1, mode_q.source_select_bit0} == 3'h0)
		|-> (watch_rise && watch_ps_q == TB_M0))
		else $error("time base 1 s tap wrong");

	short_tap_a: assert property (
		(mode_q.timebase_mode_bit && tick_w && {mode_q.source_select_bit2,
		mode_q.source_select_bit1, mode_q.source_select_bit0} == 3'h3)
		|-> (watch_rise && watch_ps_q[9:0] == 10'h3ff))
		else $error("time base short tap wrong");

	hold_clear_a: assert property (
		hold_w[*2] |-> (count_q == 8'h00 && watch_ps_q == '0 && !tick_w))
		else $error("hold did not clear");

	count_step_a: assert property (
		(!hold_w && tick_w) |=> (count_q == $past(count_q) + 8'h01))
		else $error("counter did not step");

	count_still_a: assert property (
		(!hold_w && !tick_w) |=> $stable(count_q))
		else $error("counter moved without tick");

	wrap_flag_a: assert property (
		(!hold_w && tick_w && count_q == 8'hff) |=> (count_q == 8'h00 && status_q)
		##1 (irq_q == $past(mask_q)))
		else $error("overflow not flagged");

	ready_pulse_a: assert property (
		setup_w |=> pready_q)
		else $error("ready missing after setup");

	ready_idle_a: assert property (
		!setup_w |=> !pready_q)
		else $error("ready without setup");

	irq_level_a: assert property (
		1'b1 |=> (irq_q == $past(status_q & mask_q)))
		else $error("irq does not follow flag and mask");

	flag_clear_a: assert property (
		(wr_w && paddr == `STATUS_ADDR && pwdata[`OVF_BIT] && !ovf_w) |=> !status_q)
		else $error("overflow flag not cleared");

	wrap_cov: cover property (ovf_w ##1 status_q);
	hold_cov: cover property (hold_w ##1 !hold_w);
	tb_cov: cover property (mode_q.timebase_mode_bit && tick_w);
	clear_cov: cover property (wr_w && paddr == `STATUS_ADDR && pwdata[`OVF_BIT]);
	irq_cov: cover property (irq_q ##1 !irq_q);

endmodule

/* File: dv/interval_timebase_timer_tb_top.sv */
`timescale 1ns/10ps
`include "interval_timebase_timer_consts.svh"
module interval_timebase_timer_tb_top
	import interval_timebase_timer_pkg::*;
;
	// ----------------------------------------
	// signals and table
	// ----------------------------------------
	typedef struct {
		logic [7:0] mode;
		int len;
		logic [7:0] exp;
		bit tb;
	} row_s;
	localparam int TB3 = `WATCH_HZ / (1000000 / `TB_PERIOD3_US);
	localparam int TB2 = `WATCH_HZ / (1000000 / `TB_PERIOD2_US);
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic watch_clk = 1'b0;
	logic irq;
	logic [31:0] rdata;
	logic serr;
	count_t c0;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// interval rows: mode, read spacing, ticks; time-base rows: mode, edges, count
	row_s rows [13] = '{
		'{8'h00, 2 * `SYS_DIV0, 8'h02, 0}, '{8'h01, 2 * `SYS_DIV1, 8'h02, 0},
		'{8'h02, 2 * `SYS_DIV2, 8'h02, 0}, '{8'h03, 2 * `SYS_DIV3, 8'h02, 0},
		'{8'h04, 2 * `SYS_DIV4, 8'h02, 0}, '{8'h05, 2 * `SYS_DIV5, 8'h02, 0},
		'{8'h06, 2 * `SYS_DIV6, 8'h02, 0}, '{8'h07, 2 * `SYS_DIV7, 8'h02, 0},
		'{8'h08, TB3, 8'h00, 1}, '{8'h09, TB2, 8'h00, 1}, '{8'h0a, TB2, 8'h01, 1},
		'{8'h0b, TB3 - 1, 8'h00, 1}, '{8'h0b, TB3, 8'h01, 1}};

	always #5 pclk = ~pclk;

	interval_timebase_timer DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .watch_clk(watch_clk), .irq(irq));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	// one apb transfer; entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wedges(input int n);
		repeat (n) begin
			watch_clk <= 1'b1;
			@(posedge pclk);
			watch_clk <= 1'b0;
			@(posedge pclk);
		end
		repeat (6) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 100000) begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `MODE_ADDR, 0);
		check(rdata, 32'h10, "mode reset");
		apb(0, `COUNT_ADDR, 0);
		check(rdata, 32'h0, "count reset");
		apb(0, `STATUS_ADDR, 0);
		check(rdata, 32'h0, "status reset");
		apb(0, `MASK_ADDR, 0);
		check(rdata, 32'h0, "mask reset");
		foreach (rows[i]) begin
			apb(1, `MODE_ADDR, 32'h0c);
			apb(1, `MODE_ADDR, {24'h0, rows[i].mode});
			if (rows[i].tb) begin
				wedges(rows[i].len);
				apb(0, `COUNT_ADDR, 0);
				check(rdata, {24'h0, rows[i].exp}, "time base count");
			end else begin
				apb(0, `COUNT_ADDR, 0);
				c0 = rdata[7:0];
				repeat (rows[i].len - 3) @(posedge pclk);
				apb(0, `COUNT_ADDR, 0);
				check(8'(rdata[7:0] - c0), rows[i].exp, "interval ticks");
			end
		end
		// hold codes clear a running count and freeze the watch side
		for (int k = 0; k < 4; k++) begin
			apb(1, `MODE_ADDR, 32'h07);
			repeat (40) @(posedge pclk);
			apb(1, `MODE_ADDR, 32'h0c | k);
			wedges(TB3 / 4);
			apb(0, `COUNT_ADDR, 0);
			check(rdata, 32'h0, "held count");
		end
		// the watch prescaler must not have advanced while held
		apb(1, `MODE_ADDR, 32'h0b);
		wedges(TB3 - 1);
		apb(0, `COUNT_ADDR, 0);
		check(rdata, 32'h0, "held prescaler");
		apb(1, `COUNT_ADDR, 32'h55);
		apb(0, `COUNT_ADDR, 0);
		check(rdata, 32'h0, "count read only");
		apb(1, `MODE_ADDR, 32'he7);
		apb(0, `MODE_ADDR, 0);
		check(rdata, 32'hf7, "mode readback");
		apb(0, 12'hc0, 0);
		check({rdata[30:0], serr}, 32'h1, "unmapped read");
		apb(1, 12'hc0, 32'hff);
		check(serr, 1'b1, "unmapped write");
		// overflow with mask off, then mask on, then clear
		apb(1, `MASK_ADDR, 0);
		apb(1, `MODE_ADDR, 32'h0c);
		apb(1, `MODE_ADDR, 32'h07);
		repeat (2100) @(posedge pclk);
		apb(0, `STATUS_ADDR, 0);
		check(rdata, 32'h1, "overflow flag");
		check(irq, 1'b0, "irq masked");
		apb(0, `COUNT_ADDR, 0);
		check(rdata < 32'h8, 1'b1, "count wrapped");
		apb(1, `MASK_ADDR, 32'h1);
		repeat (2) @(posedge pclk);
		check(irq, 1'b1, "irq raised");
		apb(1, `STATUS_ADDR, 0);
		apb(0, `STATUS_ADDR, 0);
		check(rdata, 32'h1, "zero write keeps flag");
		apb(1, `STATUS_ADDR, 32'h1);
		apb(0, `STATUS_ADDR, 0);
		check(rdata, 32'h0, "flag cleared");
		repeat (2) @(posedge pclk);
		check(irq, 1'b0, "irq cleared");
		// reset in mid-run returns mode and mask to their reset values
		apb(1, `MASK_ADDR, 32'h1);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, `MODE_ADDR, 0);
		check(rdata, 32'h10, "mode after reset");
		apb(0, `MASK_ADDR, 0);
		check(rdata, 32'h0, "mask after reset");
		complete_run();
	end
endmodule

/* File: include/interval_timebase_timer_consts.svh */
`ifndef INTERVAL_TIMEBASE_TIMER_CONSTS_SVH
`define INTERVAL_TIMEBASE_TIMER_CONSTS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define MODE_ADDR 12'hb0
`define COUNT_ADDR 12'hb4
`define STATUS_ADDR 12'hb8
`define MASK_ADDR 12'hbc

// ----------------------------------------
// mode register layout and reset
// ----------------------------------------
`define MODE_RESET 8'h10
`define MODE_RSVD_BIT 4
`define MODE_TB_BIT 3
`define MODE_SEL_MSB 2
`define OVF_BIT 0

// ----------------------------------------
// system prescaler taps, in pclk cycles
// ----------------------------------------
`define SYS_DIV0 8192
`define SYS_DIV1 4096
`define SYS_DIV2 2048
`define SYS_DIV3 512
`define SYS_DIV4 256
`define SYS_DIV5 128
`define SYS_DIV6 32
`define SYS_DIV7 8
`define SYS_PS_W 13

// ----------------------------------------
// time-base periods in microseconds
// ----------------------------------------
`define WATCH_HZ 32768
`define TB_PERIOD0_US 1000000
`define TB_PERIOD1_US 500000
`define TB_PERIOD2_US 250000
`define TB_PERIOD3_US 31250
`define WATCH_PS_W 15

`endif

/* File: include/interval_timebase_timer_pkg.sv */
package interval_timebase_timer_pkg;

	// mode register contents, reserved bit 4 left out
	typedef struct packed {
		logic [2:0] upper;
		logic timebase_mode_bit;
		logic source_select_bit2;
		logic source_select_bit1;
		logic source_select_bit0;
	} mode_s;

	typedef logic [7:0] count_t;

endpackage
